/* inc/acc_cfg.svh */
`ifndef ACC_CFG_SVH
`define ACC_CFG_SVH
`define ACC_GAIN_RST      24'h400000
`define ACC_OFFS_RST      24'h000000
`define ACC_GAIN_MAX      24'hFFFFFF
`define ACC_GAIN_SHIFT    22
`define ACC_OFFS_SIGN_BIT 23
`define ACC_NUM_CH        8
`define ACC_CH_W          3
`define ACC_WR_W          3
`define ACC_GR_W          3
`define ACC_RATE_BASE     16'h0040
`endif

/* inc/acc_pkg.sv */
package acc_pkg;
    typedef logic [23:0] acc_word_t;
    typedef enum logic [1:0] {
        ACC_CAL_NONE,
        ACC_CAL_OFFSET,
        ACC_CAL_GAIN
    } acc_cal_kind_t;
    typedef enum {
        ACC_ST_IDLE,
        ACC_ST_WAIT,
        ACC_ST_DONE
    } acc_state_t;
endpackage

/* inc/acc_corr_if.sv */
`timescale 1ns/1ps
interface acc_corr_if;
    logic [23:0] raw;
    logic [23:0] offs;
    logic [23:0] gain;
    logic [23:0] corr;
    modport core (input raw, input offs, input gain, output corr);
    modport user (output raw, output offs, output gain, input corr);
endinterface

/* design/acc_corr_math.sv */
`timescale 1ns/1ps
`include "acc_cfg.svh"
module acc_corr_math (
    acc_corr_if.core          bus
);
    logic signed [25:0] sum;
    logic signed [50:0] prod;
    logic signed [50:0] scaled;
    // Offset and raw are two's complement, gain is unsigned.
    assign sum    = 26'(signed'(bus.raw)) + 26'(signed'(bus.offs));
    // Sum times gain, divided by two to the twenty-second.
    assign prod   = 51'(sum) * signed'({27'h0000000, bus.gain});
    assign scaled = prod >>> `ACC_GAIN_SHIFT;
    // Clamp to the 24-bit signed result range.
    assign bus.corr = (scaled > 51'sh7FFFFF)  ? 24'h7FFFFF :
                      (scaled < -51'sh800000) ? 24'h800000 : scaled[23:0];
endmodule

/* design/acc_cal_core.sv */
`timescale 1ns/1ps
`include "acc_cfg.svh"
module acc_cal_core (
    input  wire logic                   i_mclk,
    input  wire logic                   i_rst_n,
    input  wire logic                   i_ce,
    input  wire logic [`ACC_CH_W-1:0]   i_channel,
    input  wire logic [`ACC_WR_W-1:0]   i_word_rate_select,
    input  wire logic [`ACC_GR_W-1:0]   i_gain_range_select,
    input  wire logic                   i_raw_valid,
    input  wire logic [23:0]            i_raw_result,
    input  wire logic                   i_cal_start,
    input  wire logic                   i_cal_gain,
    input  wire logic [23:0]            i_cal_target,
    input  wire logic                   i_wr_offs,
    input  wire logic                   i_wr_gain,
    input  wire logic [23:0]            i_wr_data,
    output logic                        o_res_valid,
    output logic [23:0]                 o_corrected_result,
    output logic [23:0]                 o_offset_cal_value,
    output logic [23:0]                 o_gain_cal_value,
    output logic [`ACC_GR_W-1:0]        o_cal_range,
    output logic                        o_offset_negative,
    output logic                        o_cal_busy,
    output logic                        o_sdo
);
    // Calibration storage, one offset, gain and range entry per channel.
    acc_pkg::acc_word_t     offs_ff [`ACC_NUM_CH];
    acc_pkg::acc_word_t     gain_ff [`ACC_NUM_CH];
    logic [`ACC_GR_W-1:0]   range_ff [`ACC_NUM_CH];

    // Sequencer state and the context captured when a step is taken.
    acc_pkg::acc_state_t    st_ff;
    acc_pkg::acc_state_t    nxt_st;
    acc_pkg::acc_cal_kind_t kind_ff;
    logic [`ACC_CH_W-1:0]   cch_ff;
    logic [15:0]            tick_ff;
    logic [23:0]            tgt_ff;

    // Output registers; every top-level output is driven by one of these.
    logic                   res_valid_ff;
    logic                   busy_ff;
    logic                   sdo_ff;
    logic                   neg_ff;
    logic [23:0]            corr_ff;
    logic [23:0]            ro_offs_ff;
    logic [23:0]            ro_gain_ff;
    logic [`ACC_GR_W-1:0]   ro_rng_ff;

    // Raw result with the selected channel's values feeds the datapath.
    // The math block is purely combinational, so its result is registered here.
    acc_corr_if cif ();
    assign cif.raw  = i_raw_result;
    assign cif.offs = offs_ff[i_channel];
    assign cif.gain = gain_ff[i_channel];
    acc_corr_math u_math (
        .bus (cif)
    );

    // Conversion cycle length in master clocks: doubles per word-rate code.
    // The slowest code still fits the 16-bit rate timer.
    function automatic logic [15:0] acc_conv_cycles(input logic [`ACC_WR_W-1:0] wr);
        acc_conv_cycles = 16'(`ACC_RATE_BASE << wr);
    endfunction

    // Gain needed so the measured full scale maps to target: target * 2^22 / raw.
    // A zero or too small full-scale word would overflow the gain, so the
    // quotient saturates at the all-ones code instead of wrapping to a small gain.
    function automatic logic [23:0] acc_gain_calc(input logic [23:0] tgt,
                                                  input logic [23:0] raw);
        logic [47:0] num;
        logic [47:0] q;
        num = {2'h0, tgt, 22'h0};
        q   = (raw == 24'h000000) ? 48'hFFFFFFFFFFFF : num / {24'h000000, raw};
        acc_gain_calc = (q > 48'h0000_00FF_FFFF) ? `ACC_GAIN_MAX : q[23:0];
    endfunction

    // State decode shared by the sequencer and the output registers.
    wire logic        in_idle    = (st_ff == acc_pkg::ACC_ST_IDLE);
    wire logic        in_wait    = (st_ff == acc_pkg::ACC_ST_WAIT);

    // A start is taken in idle only; a start while a step runs is dropped.
    wire logic        take_cal   = in_idle && i_cal_start;

    // The rate timer has run out, so the next raw word closes the step.
    wire logic        tick_done  = (tick_ff == 16'h0000);
    wire logic        cal_due    = in_wait && i_raw_valid && tick_done;

    // Host writes are honoured in idle only, so they never race a step's update.
    wire logic        wr_offs_ok = in_idle && i_wr_offs;
    wire logic        wr_gain_ok = in_idle && i_wr_gain;

    // Timer load value and the values that a finished step stores.
    wire logic [15:0] cal_len    = acc_conv_cycles(i_word_rate_select) - 16'h0001;
    wire logic        step_gain  = (kind_ff == acc_pkg::ACC_CAL_GAIN);
    wire logic [23:0] new_offs   = 24'(-signed'(i_raw_result));
    wire logic [23:0] new_gain   = acc_gain_calc(tgt_ff, i_raw_result);

    // Busy follows the next state, so it rises with the step being taken.
    wire logic        nxt_busy   = (nxt_st != acc_pkg::ACC_ST_IDLE);

    // Calibration sequencer: idle, wait one conversion cycle, report done.
    always_comb begin
        nxt_st = st_ff;
        unique case (st_ff)
            acc_pkg::ACC_ST_IDLE: if (take_cal) nxt_st = acc_pkg::ACC_ST_WAIT;
            acc_pkg::ACC_ST_WAIT: if (cal_due) nxt_st = acc_pkg::ACC_ST_DONE;
            acc_pkg::ACC_ST_DONE: nxt_st = acc_pkg::ACC_ST_IDLE;
        endcase
    end

    // Sequencer state and the rate timer that spans one conversion cycle.
    // The word rate is sampled once, at the start, so a change mid-step is ignored.
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            st_ff   <= acc_pkg::ACC_ST_IDLE;
            kind_ff <= acc_pkg::ACC_CAL_NONE;
            cch_ff  <= '0;
            tick_ff <= 16'h0000;
            tgt_ff  <= 24'h000000;
        end else if (i_ce) begin
            st_ff <= nxt_st;
            if (take_cal) begin
                kind_ff <= i_cal_gain ? acc_pkg::ACC_CAL_GAIN : acc_pkg::ACC_CAL_OFFSET;
                cch_ff  <= i_channel;
                tgt_ff  <= i_cal_target;
                tick_ff <= cal_len;
            end else if (in_wait && !tick_done) begin
                tick_ff <= tick_ff - 16'h0001;
            end
        end
    end

    // Per-channel storage: a finished step wins over host writes.
    // Only one range is kept per channel, so a new step overwrites the old one.
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            for (int i = 0; i < `ACC_NUM_CH; i++) begin
                offs_ff[i]  <= `ACC_OFFS_RST;
                gain_ff[i]  <= `ACC_GAIN_RST;
                range_ff[i] <= '0;
            end
        end else if (i_ce) begin
            if (cal_due) begin
                range_ff[cch_ff] <= i_gain_range_select;
                if (step_gain) gain_ff[cch_ff] <= new_gain;
                else offs_ff[cch_ff] <= new_offs;
            end else begin
                if (wr_offs_ok) offs_ff[i_channel] <= i_wr_data;
                if (wr_gain_ok) gain_ff[i_channel] <= i_wr_data;
            end
        end
    end

    // Result path: a corrected word is flagged only for raw words seen in idle.
    // Words seen during a step are never flagged, though corr_ff still takes them; only the first after the rate timer runs out feeds calibration.
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            res_valid_ff <= 1'b0;
            corr_ff      <= 24'h000000;
        end else if (i_ce) begin
            res_valid_ff <= i_raw_valid && in_idle;
            corr_ff      <= cif.corr;
        end
    end

    // Readback of the selected channel, one clock behind the channel select.
    // The sign flag comes from the same entry, so the two always agree.
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            ro_offs_ff <= `ACC_OFFS_RST;
            ro_gain_ff <= `ACC_GAIN_RST;
            ro_rng_ff  <= '0;
            neg_ff     <= 1'b0;
        end else if (i_ce) begin
            ro_offs_ff <= offs_ff[i_channel];
            ro_gain_ff <= gain_ff[i_channel];
            ro_rng_ff  <= range_ff[i_channel];
            neg_ff     <= offs_ff[i_channel][`ACC_OFFS_SIGN_BIT];
        end
    end

    // Step status: busy while a step is pending, data-out low once it is done.
    // Data-out rises again only when the next step is taken.
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            busy_ff <= 1'b0;
            sdo_ff  <= 1'b1;
        end else if (i_ce) begin
            busy_ff <= nxt_busy;
            if (take_cal) sdo_ff <= 1'b1;
            else if (cal_due) sdo_ff <= 1'b0;
        end
    end

    // Every output comes straight from its register.
    assign o_res_valid        = res_valid_ff;
    assign o_corrected_result = corr_ff;
    assign o_offset_cal_value = ro_offs_ff;
    assign o_gain_cal_value   = ro_gain_ff;
    assign o_cal_range        = ro_rng_ff;
    assign o_offset_negative  = neg_ff;
    assign o_cal_busy         = busy_ff;
    assign o_sdo              = sdo_ff;
endmodule

/* sim/acc_cal_checker.sv */
`timescale 1ns/1ps
// Watches the core's ports for slips in calibration handshakes and readback.
module acc_cal_checker (
    input logic        i_mclk, i_rst_n, i_raw_valid, i_cal_start, i_wr_gain,
    input logic [23:0] i_wr_data, o_offset_cal_value, o_gain_cal_value,
    input logic        o_res_valid, o_offset_negative, o_cal_busy, o_sdo
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    // A step is taken in idle, then stays pending with data-out high.
    sequence s_take; i_cal_start && !o_cal_busy; endsequence
    sequence s_pend; o_cal_busy && o_sdo; endsequence
    property p_start; s_take |=> s_pend; endproperty
    property p_hold; s_pend && !i_raw_valid |=> s_pend; endproperty
    property p_done; $fell(o_sdo) |-> $past(i_raw_valid) ##1 !o_cal_busy; endproperty
    property p_stand; !o_sdo && !i_cal_start |=> !o_sdo; endproperty
    property p_res; i_raw_valid && !o_cal_busy && !i_cal_start |=> o_res_valid; endproperty
    property p_nores; o_res_valid |-> $past(i_raw_valid) && !$past(o_cal_busy); endproperty
    property p_wr; i_wr_gain && !o_cal_busy |=> ##1 o_gain_cal_value == $past(i_wr_data, 2); endproperty
    property p_sign; o_offset_negative == o_offset_cal_value[23]; endproperty
    a_start: assert property (p_start) else $error("step not taken");
    a_hold: assert property (p_hold) else $error("step ended early");
    a_done: assert property (p_done) else $error("bad completion");
    a_stand: assert property (p_stand) else $error("done flag lost");
    a_res: assert property (p_res) else $error("result missing");
    a_nores: assert property (p_nores) else $error("stray result");
    a_wr: assert property (p_wr) else $error("gain write lost");
    a_sign: assert property (p_sign) else $error("sign flag wrong");
endmodule
bind acc_cal_core acc_cal_checker chk_i (.*);

/* sim/acc_host_model.sv */
`timescale 1ns/1ps
// Host side pacer: one raw word every 80 clocks while running.
module acc_host_model (
    input  wire logic        i_mclk, i_run,
    input  wire logic [23:0] i_val,
    output logic             o_raw_valid = 1'b0,
    output logic [23:0]      o_raw_result = 24'h000000
);
    int cnt = 0;
    // Slow pacing suits calibration; data toggles between words.
    always @(negedge i_mclk) begin
        cnt = i_run ? (cnt + 1) % 80 : 0;
        o_raw_valid <= i_run && cnt == 79;
        o_raw_result <= (i_run && cnt == 79) ? i_val : ~o_raw_result;
    end
endmodule

/* sim/adc_calibration_correction_bench.sv */
`timescale 1ns/1ps
module adc_calibration_correction_bench;
    logic        i_mclk = 1'b0, i_rst_n = 1'b0, i_cal_start = 1'b0, i_cal_gain = 1'b0;
    logic        i_wr_offs = 1'b0, i_wr_gain = 1'b0, run = 1'b0, res_v, busy, sdo, neg, rv;
    logic [2:0]  i_wr_sel = 3'h0, i_gr_sel = 3'h5, rng;
    logic [23:0] i_wr_data = 24'h000000, i_cal_target = 24'h7FFFFF, val = 24'h000000;
    logic [23:0] raw, corr, offs, gain;
    int          miscompares = 0, n_compared = 0, n;
    acc_host_model host (.i_mclk(i_mclk), .i_run(run), .i_val(val), .o_raw_valid(rv),
        .o_raw_result(raw));
    acc_cal_core dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(1'b1), .i_channel(3'h2),
        .i_word_rate_select(i_wr_sel), .i_gain_range_select(i_gr_sel), .i_raw_valid(rv),
        .i_raw_result(raw), .i_cal_start(i_cal_start), .i_cal_gain(i_cal_gain),
        .i_cal_target(i_cal_target), .i_wr_offs(i_wr_offs), .i_wr_gain(i_wr_gain),
        .i_wr_data(i_wr_data), .o_res_valid(res_v), .o_corrected_result(corr),
        .o_offset_cal_value(offs), .o_gain_cal_value(gain), .o_cal_range(rng),
        .o_offset_negative(neg), .o_cal_busy(busy), .o_sdo(sdo));
    // Compares one value and reports a mismatch at once.
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        if (miscompares == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // One-cycle write pulse, entered and left at a falling edge.
    task automatic wr(input logic g, input logic [23:0] d);
        {i_wr_gain, i_wr_offs, i_wr_data} = {g, !g, d};
        @(negedge i_mclk);
        {i_wr_gain, i_wr_offs} = 2'b00;
        @(negedge i_mclk);
    endtask
    // Feeds raw words until a result or a step completion shows, bounded.
    task automatic conv(input logic cal, input logic [23:0] v);
        {val, run, n} = {v, 1'b1, 32'd0};
        @(negedge i_mclk);
        while (n < 300 && (cal ? sdo !== 1'b0 : res_v !== 1'b1)) begin
            @(posedge i_mclk);
            #1 n++;
        end
        @(negedge i_mclk);
        run = 1'b0;
        chk(24'(n < 300), 24'h000001);
    endtask
    task automatic t_correct;
        chk(gain, 24'h400000);
        chk(offs, 24'h000000);
        conv(1'b0, 24'h123456);
        chk(corr, 24'h123456);
        wr(1'b0, 24'hFFFFF0);
        wr(1'b1, 24'h800000);
        @(negedge i_mclk);
        chk({23'h0, neg}, 24'h000001);
        chk(offs, 24'hFFFFF0);
        conv(1'b0, 24'h000064);
        chk(corr, 24'h0000A8);
        conv(1'b0, 24'h7FFFF0);
        chk(corr, 24'h7FFFFF);
    endtask
    // Offset or gain step at the given rate; a write during the step is refused.
    task automatic t_cal(input logic g, input logic [2:0] rate, input logic [2:0] range);
        {i_wr_sel, i_gr_sel, i_cal_gain, i_cal_start} = {rate, range, g, 1'b1};
        @(negedge i_mclk);
        i_cal_start = 1'b0;
        wr(1'b1, 24'h123456);
        conv(1'b1, 24'h000020 >> (g * 5));
        chk(24'(n > 120), {23'h0, g});
        @(negedge i_mclk);
        chk({21'h0, rng}, {21'h0, range});
        chk(offs, 24'hFFFFE0);
        chk(gain, g ? 24'hFFFFFF : 24'h800000);
    endtask
    initial forever #12.5 i_mclk = ~i_mclk;
    initial begin
        #100000;
        miscompares++;
        final_report;
    end
    initial begin
        repeat (3) @(negedge i_mclk);
        i_rst_n = 1'b1;
        t_correct;
        t_cal(1'b0, 3'h0, 3'h5);
        t_cal(1'b1, 3'h1, 3'h6);
        final_report;
    end
endmodule
